/* common/bdm_pkg.sv */
// Package: address map, field layouts and carriers for the banked data memory
package bdm_pkg;
   localparam int ADDR_W = 8;                         // File address width
   localparam int DATA_W = 8;                         // Register width
   localparam int GP_BANKS = 2;                       // General RAM banks
   localparam int SF_BANKS = 4;                       // Peripheral banks
   localparam int PRAM_BANKS = 16;                    // Banks the select nibble can name
   localparam logic [7:0] PERIPH_LO = 8'h10;          // Banked peripheral window start
   localparam logic [7:0] PERIPH_HI = 8'h17;          // Banked peripheral window end
   localparam logic [7:0] SPARE_LO = 8'h18;           // Spare unbanked storage start
   localparam logic [7:0] SPARE_HI = 8'h1F;           // Spare unbanked storage end
   localparam logic [7:0] PERIPH_TOP = 8'h1F;         // Top of peripheral-move range
   localparam logic [7:0] GP_BANK_LO = 8'h20;         // Banked general RAM start
   localparam logic [7:0] GP_BANK_HI = 8'hFF;         // Banked general RAM end
   localparam logic [7:0] IND_PTR_A = 8'h01;          // Pointer a address
   localparam logic [7:0] IND_PTR_B = 8'h09;          // Pointer b address
   localparam logic [7:0] IND_DATA_A = 8'h00;         // Indirect data port via pointer a
   localparam logic [7:0] IND_DATA_B = 8'h08;         // Indirect data port via pointer b
   localparam logic [7:0] BANK_SEL_ADDR = 8'h0F;      // Bank select register address
   localparam int SF_NIB_LSB = 0;                     // Peripheral bank nibble position
   localparam int GP_NIB_LSB = 4;                     // RAM bank nibble position
   localparam logic [7:0] BANK_SEL_RST = 8'h00;       // Bank select reset value
   localparam logic [7:0] PTR_RST = 8'h00;            // Pointer reset value
   localparam logic [7:0] CORE_RST = 8'h00;           // Core register reset value
   localparam logic [7:0] DATA_ZERO = 8'h00;          // Read of an empty location

   // Access operations issued by the core
   typedef enum logic [2:0] {
      BDM_OP_IDLE = 3'b000,
      BDM_OP_READ = 3'b001,
      BDM_OP_WRITE = 3'b010,
      BDM_OP_P2F = 3'b011,
      BDM_OP_F2P = 3'b100,
      BDM_OP_LDRAM = 3'b101,
      BDM_OP_LDPER = 3'b110
   } bdm_op_t;

   // Core request
   typedef struct packed {
      bdm_op_t op;           // Operation
      logic [7:0] faddr;     // File address
      logic [7:0] paddr;     // Peripheral-range address
      logic [7:0] wdata;     // Write data or bank literal
   } bdm_req_t;

   // Answer to the core
   typedef struct packed {
      logic valid;           // Read data valid
      logic [7:0] rdata;     // Read data
   } bdm_rsp_t;
endpackage : bdm_pkg

/* logic/bdm_data_memory.sv */
// Banked data memory: general RAM, special-function area, pointers, bank select
`timescale 1ns/1ps
module bdm_data_memory
   import bdm_pkg::*;
(
   input wire logic ref_clk_i,                      // 50 MHz core clock
   input wire logic resetn_i,                       // Asynchronous reset, active low
   input wire bdm_req_t req_i,                      // Core request
   input wire logic [SF_BANKS*8*DATA_W-1:0] periph_i, // Peripheral status inputs
   output bdm_rsp_t rsp_o,                          // Registered read answer
   output logic [SF_BANKS*8*DATA_W-1:0] periph_o,   // Peripheral control registers
   output logic [7:0] bank_select_reg_o             // Bank select value
);
   localparam int PWIN = 8;                          // Peripheral window depth

   // General RAM storage, never reset
   logic [7:0] gram_r [GP_BANKS][GP_BANK_LO:GP_BANK_HI];
   logic [7:0] spare_r [SPARE_LO:SPARE_HI];
   logic [7:0] core_r [0:PERIPH_LO-1];                          // Unbanked core regs
   logic [7:0] periph_r [SF_BANKS][PWIN];                       // Banked peripheral regs
   logic [7:0] bank_select_reg_r;                               // Bank select
   logic [7:0] bank_select_reg_nxt;
   bdm_rsp_t rsp_r;
   bdm_rsp_t rsp_nxt;

   // Physical location classes
   typedef enum logic [2:0] {
      BDM_LOC_CORE = 3'b000,
      BDM_LOC_BSR = 3'b001,
      BDM_LOC_PER = 3'b010,
      BDM_LOC_SPARE = 3'b011,
      BDM_LOC_GRAM = 3'b100,
      BDM_LOC_NONE = 3'b101
   } bdm_loc_t;

   logic [7:0] src_addr;        // Effective read address
   logic [7:0] dst_addr;        // Effective write address
   logic do_rd;                 // Read phase
   logic do_wr;                 // Write phase
   logic [7:0] rd_val;          // Value read
   logic [7:0] wr_val;          // Value written
   logic [3:0] gp_bank;         // Current RAM bank nibble
   logic [3:0] sf_bank;         // Current peripheral bank nibble

   // Nibble views of the bank select register
   assign gp_bank = bank_select_reg_r[GP_NIB_LSB+:4];
   assign sf_bank = bank_select_reg_r[SF_NIB_LSB+:4];

   // Resolve indirect data ports through the pointers
   function automatic logic [7:0] resolve(input logic [7:0] a);
      if (a == IND_DATA_A) begin
         return core_r[IND_PTR_A[3:0]];
      end else if (a == IND_DATA_B) begin
         return core_r[IND_PTR_B[3:0]];
      end else begin
         return a;
      end
   endfunction : resolve

   // Classify a resolved address
   function automatic bdm_loc_t classify(input logic [7:0] a);
      if (a == BANK_SEL_ADDR) begin
         return BDM_LOC_BSR;
      end else if (a < PERIPH_LO) begin
         return BDM_LOC_CORE;
      end else if (a <= PERIPH_HI) begin
         return BDM_LOC_PER;
      end else if (a <= SPARE_HI) begin
         return BDM_LOC_SPARE;
      end else begin
         return BDM_LOC_GRAM;
      end
   endfunction : classify

   // Source and destination per operation
   always_comb begin
      src_addr = req_i.faddr;
      dst_addr = req_i.faddr;
      do_rd = 1'b0;
      do_wr = 1'b0;
      case (req_i.op)
         // Plain read of the file address
         BDM_OP_READ: begin
            do_rd = 1'b1;
         end
         // Plain write of the request data
         BDM_OP_WRITE: begin
            do_wr = 1'b1;
         end
         // Copy from the peripheral range into the file
         BDM_OP_P2F: begin
            src_addr = req_i.paddr & PERIPH_TOP;
            do_rd = 1'b1;
            do_wr = 1'b1;
         end
         // Copy from the file into the peripheral range
         BDM_OP_F2P: begin
            dst_addr = req_i.paddr & PERIPH_TOP;
            do_rd = 1'b1;
            do_wr = 1'b1;
         end
         // Idle and bank loads touch no file location
         default: begin
         end
      endcase
      // Indirect ports turn into the address their pointer holds
      src_addr = resolve(src_addr);
      dst_addr = resolve(dst_addr);
   end

   // Read mux
   always_comb begin
      rd_val = DATA_ZERO;
      case (classify(src_addr))
         BDM_LOC_BSR: rd_val = bank_select_reg_r;
         BDM_LOC_CORE: rd_val = core_r[src_addr[3:0]];
         BDM_LOC_PER: begin
            // An absent peripheral bank reads as zero
            if (sf_bank < SF_BANKS) begin
               rd_val = periph_r[sf_bank[1:0]][src_addr[2:0]];
            end
         end
         BDM_LOC_SPARE: rd_val = spare_r[src_addr];
         BDM_LOC_GRAM: begin
            // An absent RAM bank reads as zero
            if (gp_bank < GP_BANKS) begin
               rd_val = gram_r[gp_bank[0]][src_addr];
            end
         end
         default: rd_val = DATA_ZERO;
      endcase
      wr_val = (req_i.op == BDM_OP_WRITE) ? req_i.wdata : rd_val;
   end

   // Bank select next value
   always_comb begin
      bank_select_reg_nxt = bank_select_reg_r;
      if (req_i.op == BDM_OP_LDRAM) begin
         bank_select_reg_nxt[GP_NIB_LSB+:4] = req_i.wdata[3:0];
      end else if (req_i.op == BDM_OP_LDPER) begin
         bank_select_reg_nxt[SF_NIB_LSB+:4] = req_i.wdata[3:0];
      end else if (do_wr && classify(dst_addr) == BDM_LOC_BSR) begin
         bank_select_reg_nxt = wr_val;
      end
      rsp_nxt.valid = do_rd && !do_wr;
      rsp_nxt.rdata = do_rd ? rd_val : DATA_ZERO;
   end

   // Control state with reset
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bank_select_reg_r <= BANK_SEL_RST;
         rsp_r <= '0;
      end else begin
         bank_select_reg_r <= bank_select_reg_nxt;
         rsp_r <= rsp_nxt;
      end
   end

   // Core and peripheral registers: static, reset to known values
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         // Core registers, pointers included, come up cleared
         for (int i = 0; i < PERIPH_LO; i++) begin
            core_r[i] <= CORE_RST;
         end
         for (int b = 0; b < SF_BANKS; b++) begin
            for (int j = 0; j < PWIN; j++) begin
               periph_r[b][j] <= CORE_RST;
            end
         end
      end else if (do_wr) begin
         case (classify(dst_addr))
            BDM_LOC_CORE: core_r[dst_addr[3:0]] <= wr_val;
            BDM_LOC_PER: begin
               // Writes to an absent peripheral bank are dropped
               if (sf_bank < SF_BANKS) begin
                  periph_r[sf_bank[1:0]][dst_addr[2:0]] <= wr_val;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // General RAM and spares: no reset at all
   always_ff @(posedge ref_clk_i) begin
      // Spares are plain storage, the same in every bank
      if (do_wr && classify(dst_addr) == BDM_LOC_SPARE) begin
         spare_r[dst_addr] <= wr_val;
      end
      // Writes to an absent RAM bank are dropped
      if (do_wr && classify(dst_addr) == BDM_LOC_GRAM && gp_bank < GP_BANKS) begin
         gram_r[gp_bank[0]][dst_addr] <= wr_val;
      end
   end

   // Peripheral control outputs, one per register
   for (genvar g = 0; g < SF_BANKS * PWIN; g++) begin : g_pout
      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            periph_o[g*DATA_W+:DATA_W] <= CORE_RST;
         end else begin
            periph_o[g*DATA_W+:DATA_W] <= periph_r[g/PWIN][g%PWIN] ^ DATA_ZERO;
         end
      end
   end

   // Outputs come straight from their registers
   assign rsp_o = rsp_r;
   assign bank_select_reg_o = bank_select_reg_r;
endmodule : bdm_data_memory

/* tb/bdm_data_memory_sva.sv */
// Checker: port timing and bank behaviour of the banked data memory
`timescale 1ns/1ps
module bdm_data_memory_sva
   import bdm_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire bdm_req_t req_i,
   input wire logic [SF_BANKS*8*DATA_W-1:0] periph_i,
   input wire bdm_rsp_t rsp_o,
   input wire logic [SF_BANKS*8*DATA_W-1:0] periph_o,
   input wire logic [7:0] bank_select_reg_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   AST_READ_ANSWER: assert property (req_i.op == BDM_OP_READ |=> rsp_o.valid)
      else $error("read not answered");
   AST_NO_ANSWER: assert property (req_i.op != BDM_OP_READ |=> !rsp_o.valid)
      else $error("answer without read");
   AST_LOAD_RAM: assert property (req_i.op == BDM_OP_LDRAM |=>
      bank_select_reg_o == {$past(req_i.wdata[3:0]), $past(bank_select_reg_o[3:0])})
      else $error("ram bank literal not loaded");
   AST_LOAD_PER: assert property (req_i.op == BDM_OP_LDPER |=>
      bank_select_reg_o == {$past(bank_select_reg_o[7:4]), $past(req_i.wdata[3:0])})
      else $error("peripheral bank literal not loaded");
   AST_BANK_HOLD: assert property (req_i.op inside {BDM_OP_IDLE, BDM_OP_READ} |=>
      $stable(bank_select_reg_o)) else $error("bank select moved");
   AST_BSEL_READ: assert property (req_i.op == BDM_OP_READ &&
      req_i.faddr == BANK_SEL_ADDR |=> rsp_o.rdata == $past(bank_select_reg_o))
      else $error("bank select read wrong");
   AST_PERIPH_OUT: assert property (req_i.op == BDM_OP_WRITE &&
      req_i.faddr inside {[PERIPH_LO:PERIPH_HI]} && bank_select_reg_o[3:0] < SF_BANKS |->
      ##2 periph_o[$past({bank_select_reg_o[1:0], req_i.faddr[2:0]}, 2)*8 +: 8] ==
      $past(req_i.wdata, 2)) else $error("peripheral output not updated");
   AST_REFUSED_ZERO: assert property (req_i.op == BDM_OP_READ &&
      req_i.faddr >= GP_BANK_LO && bank_select_reg_o[7:4] >= GP_BANKS |=>
      rsp_o.rdata == DATA_ZERO) else $error("absent bank read not zero");
   AST_RESET_CLEAR: assert property (disable iff (1'b0) !resetn_i |->
      bank_select_reg_o == BANK_SEL_RST && !rsp_o.valid && periph_o == '0)
      else $error("outputs not cleared in reset");
endmodule : bdm_data_memory_sva

/* tb/bdm_core_model.sv */
// Core model: issues direct, indirect, move and bank-load requests
`timescale 1ns/1ps
module bdm_core_model
   import bdm_pkg::*;
(
   input wire logic ref_clk_i,
   input wire bdm_rsp_t rsp_i,
   output bdm_req_t req_o
);
   int gap = 0; // Idle cycles before each request, for a slow core
   initial req_o = '0;
   // Issue one request after the gap; it stays up until a later call idles or replaces it
   task op(input bdm_op_t o, input logic [7:0] f, input logic [7:0] p, input logic [7:0] w);
      repeat (gap) @(posedge ref_clk_i) req_o <= '0;
      @(posedge ref_clk_i) req_o <= '{o, f, p, w};
   endtask : op
   // Read one location and pick up the answer one cycle after it is issued
   task rd(input logic [7:0] f, output logic [7:0] d, output logic v);
      op(BDM_OP_READ, f, 8'h00, 8'h00);
      @(posedge ref_clk_i) req_o <= '0;
      #1 d = rsp_i.rdata;
      v = rsp_i.valid;
   endtask : rd
endmodule : bdm_core_model

/* tb/bdm_data_memory_test.sv */
// Testbench: scenario tasks for the banked data memory
`timescale 1ns/1ps
module bdm_data_memory_test;
   import bdm_pkg::*;
   logic clk;
   logic rstn = 1'b1; // Active-low reset, released until the first edge
   bdm_req_t req;
   bdm_rsp_t rsp;
   logic [SF_BANKS*8*DATA_W-1:0] po;
   logic [7:0] bsel;
   int err_count = 0, checks_done = 0, cyc = 0;
   bdm_data_memory dut(.ref_clk_i(clk), .resetn_i(rstn), .req_i(req), .periph_i('0),
      .rsp_o(rsp), .periph_o(po), .bank_select_reg_o(bsel));
   bdm_core_model m(.ref_clk_i(clk), .rsp_i(rsp), .req_o(req));
   initial clk = 1'b0;
   always #10 clk = ~clk;
   // Compare one byte
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Read and compare data and the valid flag
   task rc(input logic [7:0] f, input logic [7:0] e);
      logic [7:0] d;
      logic v;
      m.rd(f, d, v);
      chk(d, e);
      chk({7'h00, v}, 8'h01);
   endtask : rc
   task wr(input logic [7:0] f, input logic [7:0] w);
      m.op(BDM_OP_WRITE, f, 8'h00, w);
   endtask : wr
   task ld(input bdm_op_t o, input logic [3:0] n);
      m.op(o, 8'h00, 8'h00, {4'h0, n});
   endtask : ld
   task t_ram;
      ld(BDM_OP_LDRAM, 4'h0); wr(8'h20, 8'h55); ld(BDM_OP_LDRAM, 4'h1); wr(8'h20, 8'hAA);
      rc(8'h20, 8'hAA);
      ld(BDM_OP_LDRAM, 4'h0); rc(8'h20, 8'h55);
      ld(BDM_OP_LDRAM, 4'h2); wr(8'h20, 8'h77); rc(8'h20, 8'h00);
      ld(BDM_OP_LDRAM, 4'h0); rc(8'h20, 8'h55);
      $display("ram banks done");
   endtask : t_ram
   task t_spare;
      for (int i = 0; i < 8; i++) wr(SPARE_LO + 8'(i), 8'hC0 + 8'(i));
      ld(BDM_OP_LDRAM, 4'h1); ld(BDM_OP_LDPER, 4'h3);
      for (int i = 0; i < 8; i++) rc(SPARE_LO + 8'(i), 8'hC0 + 8'(i));
      $display("spares done");
   endtask : t_spare
   task t_periph;
      for (int b = 0; b < 4; b++) begin
         ld(BDM_OP_LDPER, 4'(b)); wr(PERIPH_LO + 8'(b), 8'h40 + 8'(b));
      end
      for (int b = 0; b < 4; b++) begin
         ld(BDM_OP_LDPER, 4'(b)); rc(PERIPH_LO + 8'(b), 8'h40 + 8'(b));
         chk(po[(b * 9) * 8 +: 8], 8'h40 + 8'(b));
      end
      ld(BDM_OP_LDPER, 4'h0); rc(8'h11, 8'h00);
      $display("peripheral banks done");
   endtask : t_periph
   task t_move;
      m.gap = 2;
      ld(BDM_OP_LDRAM, 4'h0); wr(8'h1A, 8'h3C);
      m.op(BDM_OP_P2F, 8'h90, 8'h1A, 8'h00); rc(8'h90, 8'h3C);
      m.op(BDM_OP_F2P, 8'h90, 8'h1F, 8'h00); rc(8'h1F, 8'h3C);
      ld(BDM_OP_LDPER, 4'h2); m.op(BDM_OP_F2P, 8'h90, 8'h13, 8'h00);
      rc(8'h13, 8'h3C); chk(po[19 * 8 +: 8], 8'h3C);
      m.gap = 0;
      $display("moves done");
   endtask : t_move
   task t_indirect;
      ld(BDM_OP_LDRAM, 4'h0); wr(8'h40, 8'h11); wr(IND_PTR_A, 8'h40);
      ld(BDM_OP_LDRAM, 4'h1); wr(IND_DATA_A, 8'h5A); rc(8'h40, 8'h5A);
      ld(BDM_OP_LDRAM, 4'h0); rc(IND_DATA_A, 8'h11);
      wr(IND_PTR_B, 8'h1C); wr(IND_DATA_B, 8'h6D); rc(8'h1C, 8'h6D);
      $display("indirect done");
   endtask : t_indirect
   task t_reset;
      wr(BANK_SEL_ADDR, 8'h13); rc(BANK_SEL_ADDR, 8'h13); chk(bsel, 8'h13);
      wr(8'h30, 8'hE7); m.op(BDM_OP_IDLE, 8'h00, 8'h00, 8'h00);
      @(posedge clk) rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      #1 chk(bsel, BANK_SEL_RST);
      ld(BDM_OP_LDRAM, 4'h1); rc(8'h30, 8'hE7);
      $display("reset retention done");
   endtask : t_reset
   task finish_test;
      $display("checks=%0d mismatches=%0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         finish_test;
      end
   end
   initial begin
      // Reset goes low on the first edge, once every process is waiting on it
      @(posedge clk) rstn <= 1'b0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_ram; t_spare; t_periph; t_move; t_indirect; t_reset;
      finish_test;
   end
endmodule : bdm_data_memory_test
bind bdm_data_memory bdm_data_memory_sva u_sva(.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
   .req_i(req_i), .periph_i(periph_i), .rsp_o(rsp_o), .periph_o(periph_o),
   .bank_select_reg_o(bank_select_reg_o));
